// ### dv/ips_core_model.sv
// processor core model: sleeps until woken, then takes levels
`timescale 1ns/100ps
module ips_core_model
(
   clock,
   rst_n,
   sleep,
   irq_level,
   wake_request,
   awake_q,
   level_q
);
   input  wire logic       clock;
   input  wire logic       rst_n;
   input  wire logic       sleep;
   input  wire logic [2:0] irq_level;
   input  wire logic       wake_request;
   output logic            awake_q;
   output logic [2:0]      level_q;
   logic                   awake_d;
   logic [2:0]             level_d;
   // asleep, levels are ignored: only a key press restarts it
   always_comb
   begin
      awake_d = wake_request | (awake_q & ~sleep);
      level_d = awake_q ? irq_level : 3'h0;
   end
   always_ff @(posedge clock)
   begin
      awake_q <= rst_n ? awake_d : 1'b0;
      level_q <= rst_n ? level_d : 3'h0;
   end
endmodule

// ### dv/ips_pending_monitor.sv
// assertion checker bound to the pending sources block
`timescale 1ns/100ps
`include "ips_defs.svh"
module ips_pending_monitor
#(
   parameter int KEY_LINES = 8
)
(
   input wire logic                 clock,
   input wire logic                 rst_n,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [11:0]          paddr,
   input wire logic [31:0]          prdata,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire logic [KEY_LINES-1:0] keypad_input_lines,
   input wire logic [2:0]           irq_level,
   input wire logic                 wake_request
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////
   // bus answers: one wait-free access, one cycle wide
   property p_answer;
      psel && !penable |=> pready ##1 !pready;
   endproperty
   a_answer: assert property (p_answer) else $error("ready late or long");
   property p_idle;
      !psel |=> !pready;
   endproperty
   a_idle: assert property (p_idle) else $error("ready while idle");
   property p_cause;
      pready |-> $past(psel) && !$past(penable);
   endproperty
   a_cause: assert property (p_cause) else $error("ready without setup");
   // refusals carry no data and only hit unmapped places
   property p_err_data;
      pslverr |-> pready && prdata == 32'h00000000;
   endproperty
   a_err_data: assert property (p_err_data) else $error("error with data");
   property p_err_map;
      pready |-> pslverr == !(paddr inside {`IPS_CTRL_ADDR, `IPS_MASK_ADDR,
         `IPS_STAT_ADDR, `IPS_PEND_ADDR, `IPS_KCLR_ADDR});
   endproperty
   a_err_map: assert property (p_err_map) else $error("bad error flag");
   // reserved pending positions never read back set
   property p_resv;
      pready && !pwrite && paddr inside {`IPS_PEND_ADDR, `IPS_STAT_ADDR}
         |-> (prdata & ~`IPS_VALID_BITS) == 32'h00000000;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved bit set");
   property p_level;
      irq_level inside {3'h0, 3'h1, 3'h4, 3'h5, 3'h6};
   endproperty
   a_level: assert property (p_level) else $error("odd level");
   property p_nowake;
      keypad_input_lines == '0 |=> !wake_request;
   endproperty
   a_nowake: assert property (p_nowake) else $error("wake, no key");
endmodule
bind ips_pending ips_pending_monitor #(.KEY_LINES(KEY_LINES)) u_mon
(
   .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .keypad_input_lines(keypad_input_lines),
   .irq_level(irq_level), .wake_request(wake_request)
);

// ### dv/tb_ips_pending.sv
// self-checking bench for the pending sources block
`timescale 1ns/100ps
`include "ips_defs.svh"
module tb_ips_pending;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [3:0]  key_n = 4'hF;
   logic        lvl1_n = 1'b1;
   logic        pen = 1'b0;
   logic [7:0]  keypad = 8'h00;
   logic [5:0]  src = 6'h00;
   logic [2:0]  irq_level;
   logic        wake_request;
   logic        sleep = 1'b1;
   logic        awake_q;
   logic [2:0]  level_q;
   logic [31:0] rd;
   logic        err;
   int          mismatches = 0;
   int          checks = 0;
   // on-chip sources in src order: spi timer uart wdog rtc pwm
   int          pos [6] = '{0, 1, 2, 3, 4, 7};
   logic [31:0] lvl [6] = '{32'h4, 32'h6, 32'h4, 32'h4, 32'h4, 32'h6};
   ////////////////////////////////
   always #50 clock = ~clock;
   ips_pending DUT
   (
      .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .ext_level1_request_n(lvl1_n), .keyline0_request_n(key_n[0]),
      .keyline1_request_n(key_n[1]), .keyline2_request_n(key_n[2]),
      .keyline3_request_n(key_n[3]), .pen_request_line(pen),
      .keypad_input_lines(keypad), .pwm_rollover(src[5]),
      .rtc_request(src[4]), .watchdog_request(src[3]),
      .uart_request(src[2]), .timer_event_flag(src[1]),
      .spi_done(src[0]), .irq_level(irq_level),
      .wake_request(wake_request)
   );
   ips_core_model u_core
   (
      .clock(clock), .rst_n(rst_n), .sleep(sleep), .irq_level(irq_level),
      .wake_request(wake_request), .awake_q(awake_q), .level_q(level_q)
   );
   ////////////////////////////////
   // one apb transfer; request held until ready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      // only the watchdog ends a wait that never sees ready
      while (pready !== 1'b1)
      begin
         @(posedge clock);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      chk(rd, exp);
   endtask
   // sources are sampled each edge; three edges let levels settle
   task automatic settle;
      repeat (3) @(posedge clock);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////
   // main sequence
   initial
   begin
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      sleep <= 1'b0;
      rdchk(`IPS_CTRL_ADDR, `IPS_CTRL_RST);
      rdchk(`IPS_MASK_ADDR, `IPS_MASK_RST);
      rdchk(`IPS_PEND_ADDR, `IPS_PEND_RST);
      apb(1'b0, 12'h308, 32'h00000000);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h00000000);
      apb(1'b1, `IPS_MASK_ADDR, 32'h00000000);
      for (int i = 0; i < 6; i++)
      begin
         src <= 6'h01 << i;
         settle;
         chk({29'h0, irq_level}, lvl[i]);
         rdchk(`IPS_STAT_ADDR, 32'h1 << pos[i]);
      end
      src <= 6'h00;
      chk({31'h0, awake_q}, 32'h0);
      for (int i = 0; i < 8; i++)
      begin
         keypad <= 8'h01 << i;
         rdchk(`IPS_PEND_ADDR, 32'h00000040);
      end
      chk({29'h0, irq_level}, 32'h4);
      chk({31'h0, awake_q}, 32'h1);
      chk({29'h0, level_q}, 32'h4);
      keypad <= 8'h00;
      // masked source pends but stays out of status and level
      apb(1'b1, `IPS_MASK_ADDR, `IPS_VALID_BITS);
      src <= 6'h04;
      rdchk(`IPS_PEND_ADDR, 32'h00000004);
      rdchk(`IPS_STAT_ADDR, 32'h00000000);
      chk({29'h0, irq_level}, 32'h0);
      src <= 6'h00;
      apb(1'b1, `IPS_MASK_ADDR, 32'h00000000);
      // level-1 request, edge mode then level mode
      apb(1'b1, `IPS_CTRL_ADDR, 32'h00000001);
      lvl1_n <= 1'b0;
      settle;
      lvl1_n <= 1'b1;
      rdchk(`IPS_PEND_ADDR, 32'h00010000);
      chk({29'h0, irq_level}, 32'h1);
      apb(1'b1, `IPS_PEND_ADDR, 32'h00000000);
      rdchk(`IPS_PEND_ADDR, 32'h00010000);
      apb(1'b1, `IPS_PEND_ADDR, 32'h00010000);
      rdchk(`IPS_PEND_ADDR, 32'h00000000);
      apb(1'b1, `IPS_CTRL_ADDR, 32'h00000000);
      lvl1_n <= 1'b0;
      apb(1'b1, `IPS_PEND_ADDR, 32'h00010000);
      rdchk(`IPS_PEND_ADDR, 32'h00010000);
      lvl1_n <= 1'b1;
      rdchk(`IPS_PEND_ADDR, 32'h00000000);
      // keylines in edge mode clear only through the port register
      apb(1'b1, `IPS_CTRL_ADDR, 32'h00000F00);
      key_n <= 4'h0;
      settle;
      key_n <= 4'hF;
      apb(1'b1, `IPS_PEND_ADDR, 32'h00000F00);
      rdchk(`IPS_PEND_ADDR, 32'h00000F00);
      chk({29'h0, irq_level}, 32'h4);
      apb(1'b1, `IPS_KCLR_ADDR, 32'h00000005);
      rdchk(`IPS_PEND_ADDR, 32'h00000A00);
      // pen polarity flips which line level pends
      // keyline edge bits stay set so their pending bits survive
      apb(1'b1, `IPS_CTRL_ADDR, 32'h00000F04);
      rdchk(`IPS_PEND_ADDR, 32'h00100A00);
      chk({29'h0, irq_level}, 32'h5);
      pen <= 1'b1;
      rdchk(`IPS_PEND_ADDR, 32'h00000A00);
      apb(1'b1, `IPS_CTRL_ADDR, 32'h00000000);
      rdchk(`IPS_PEND_ADDR, 32'h00100000);
      // pen edge mode: a pen-down edge pends until written off
      apb(1'b1, `IPS_CTRL_ADDR, 32'h00000006);
      settle;
      pen <= 1'b0;
      settle;
      pen <= 1'b1;
      rdchk(`IPS_PEND_ADDR, 32'h00100000);
      apb(1'b1, `IPS_PEND_ADDR, 32'h00100000);
      rdchk(`IPS_PEND_ADDR, 32'h00000000);
      final_report;
   end
   // watchdog: the sequence needs well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge clock);
      $display("ERROR %0t watchdog ran out", $time);
      mismatches++;
      final_report;
   end
endmodule

// ### rtl/ips_defs.svh
// constants for the interrupt pending sources block
// Summary of operation
// RL1 - edge level-1 pending clears on write-one only
// RL2 - level level-1 request cleared at its source
// RL3 - software writes zero to bits 15..12
// RL4 - keylines pend at level 4, port-clear
// RL5 - modulator rollover pends at level 6
// RL6 - keypad pending has own bit, level 4
// RL7 - software leaves bit 5 at default
// RL8 - calendar clock request pends at level 4
// RL9 - watchdog request pends at level 4
// RL10 - uart service request pends at level 4
// RL11 - timer event pends at level 6
// RL12 - spi done pends level 4, cleared remotely
// RL13 - eight keypad lines ORed into one request
// RL14 - keypad request wakes the sleeping core
// RL15 - pen line is level 5 with pull-up
// RL16 - pen down and pen up both signalled
// RL17 - pen polarity chosen by control bit
// RL18 - pending sets even masked; status needs unmask
// RL19 - pending read-only except write-one clears
// RL20 - pen polarity applied before detection
`ifndef IPS_DEFS_SVH
`define IPS_DEFS_SVH

// register byte offsets
`define IPS_CTRL_ADDR   12'h300
`define IPS_MASK_ADDR   12'h304
`define IPS_STAT_ADDR   12'h30C
`define IPS_PEND_ADDR   12'h310
`define IPS_KCLR_ADDR   12'h318

// pending bit positions
`define IPS_B_SPI       0
`define IPS_B_TMR       1
`define IPS_B_UART      2
`define IPS_B_WDOG      3
`define IPS_B_RTC       4
`define IPS_B_KEYPAD    6
`define IPS_B_PWM       7
`define IPS_B_KEY0      8
`define IPS_B_LVL1      16
`define IPS_B_PEN       20

// control register fields
`define IPS_C_LVL1_EDGE 0
`define IPS_C_PEN_EDGE  1
`define IPS_C_PEN_POL   2
`define IPS_C_KEY_EDGE0 8

// implemented bits and reset values
`define IPS_VALID_BITS  32'h00110FDF
`define IPS_CTRL_BITS   32'h00000F07
`define IPS_CTRL_RST    32'h00000000
`define IPS_MASK_RST    32'h00110FDF
`define IPS_PEND_RST    32'h00000000

// priority levels
`define IPS_LVL_NONE    3'h0
`define IPS_LVL_EXT1    3'h1
`define IPS_LVL_FOUR    3'h4
`define IPS_LVL_PEN     3'h5
`define IPS_LVL_SIX     3'h6

`endif

// ### rtl/ips_pending.sv
// interrupt pending/status sources with apb register access
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "ips_defs.svh"
module ips_pending
#(
   parameter int KEY_LINES = 8
)
(
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire logic         ext_level1_request_n,
   input  wire logic         keyline0_request_n,
   input  wire logic         keyline1_request_n,
   input  wire logic         keyline2_request_n,
   input  wire logic         keyline3_request_n,
   input  wire logic         pen_request_line,
   input  wire logic [KEY_LINES-1:0] keypad_input_lines,
   input  wire logic         pwm_rollover,
   input  wire logic         rtc_request,
   input  wire logic         watchdog_request,
   input  wire logic         uart_request,
   input  wire logic         timer_event_flag,
   input  wire logic         spi_done,
   output logic [2:0]        irq_level,
   output logic              wake_request
);

   ////////////////////////////////////////////////////////////////////////
   // elaboration checks

   // the keypad OR tree serves one to thirty-two lines
   if (KEY_LINES < 1 || KEY_LINES > 32)
   begin : g_bad_keys
      $error("ips_pending: KEY_LINES must lie in 1..32");
   end

   // the four keyline bits must stay inside the implemented field
   if (`IPS_B_KEY0 + 4 > 12)
   begin : g_bad_keyfield
      $error("ips_pending: keyline field overruns bit 11");
   end

   // the keyline edge bits must fit the control word
   if (`IPS_C_KEY_EDGE0 + 4 > 32)
   begin : g_bad_ctrlfield
      $error("ips_pending: keyline edge field overruns the word");
   end

   ////////////////////////////////////////////////////////////////////////
   // declarations

   localparam int EXT_N = 6;

   ips_pkg::ips_word_type  ctrl_q;
   ips_pkg::ips_word_type  ctrl_d;
   ips_pkg::ips_word_type  mask_q;
   ips_pkg::ips_word_type  mask_d;
   ips_pkg::ips_word_type  prdata_q;
   ips_pkg::ips_word_type  prdata_d;
   logic                   pready_q;
   logic                   pready_d;
   logic                   pslverr_q;
   logic                   pslverr_d;
   ips_pkg::ips_level_type level_q;
   ips_pkg::ips_level_type level_d;
   logic                   wake_q;
   logic                   wake_d;

   logic                   wr_done;
   logic                   addr_ok;
   ips_pkg::ips_word_type  pend;
   ips_pkg::ips_word_type  stat;
   logic                   keypad_request;
   logic                   pen_active;
   logic [EXT_N-1:0]       ext_active;
   logic [EXT_N-1:0]       ext_edge;
   logic [EXT_N-1:0]       ext_clear;
   logic [EXT_N-1:0]       ext_pend;
   logic [3:0]             keyline_n;
   ips_pkg::ips_level_type bit_level [32];

   ////////////////////////////////////////////////////////////////////////
   // source conditioning

   // pen sense flipped by the polarity bit ahead of detection
   // so both pen-down and pen-up can be the active event;
   // the pull-up sits in the pad, not here
   assign pen_active = pen_request_line ^ ctrl_q[`IPS_C_PEN_POL]; // RL17 RL20

   // any pressed key raises the single keypad request
   assign keypad_request = |keypad_input_lines; // RL13

   assign keyline_n = {keyline3_request_n, keyline2_request_n,
                       keyline1_request_n, keyline0_request_n};

   // external slot 0 level1, 1..4 keylines, 5 pen
   always_comb
   begin
      ext_active    = {pen_active, ~keyline_n, ~ext_level1_request_n};
      ext_edge[0]   = ctrl_q[`IPS_C_LVL1_EDGE];
      ext_edge[4:1] = ctrl_q[`IPS_C_KEY_EDGE0 +: 4];
      ext_edge[5]   = ctrl_q[`IPS_C_PEN_EDGE]; // RL16
   end

   ////////////////////////////////////////////////////////////////////////
   // apb decode

   assign wr_done = psel & penable & pready_q & pwrite;

   // write-one clears: level1 and pen through the pending word,
   // keylines only through the interrupt port clear word
   always_comb
   begin
      ext_clear = '0;
      if (wr_done && paddr == `IPS_PEND_ADDR)
      begin
         ext_clear[0] = pwdata[`IPS_B_LVL1]; // RL1
         ext_clear[5] = pwdata[`IPS_B_PEN];
      end
      if (wr_done && paddr == `IPS_KCLR_ADDR)
      begin
         ext_clear[4:1] = pwdata[3:0]; // RL4
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // external request cells

   for (genvar g = 0; g < EXT_N; g++)
   begin : g_ext
      ips_src_cell u_cell
      (
         .clock     (clock),
         .rst_n     (rst_n),
         .active    (ext_active[g]),
         .edge_mode (ext_edge[g]),
         .clear     (ext_clear[g]),
         .pending   (ext_pend[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // pending and status words

   // pending follows every request, masked or not
   always_comb
   begin
      pend                 = `IPS_PEND_RST;
      pend[`IPS_B_LVL1]    = ext_pend[0]; // RL1
      pend[`IPS_B_KEY0+:4] = ext_pend[4:1]; // RL4
      pend[`IPS_B_PEN]     = ext_pend[5]; // RL15
      pend[`IPS_B_PWM]     = pwm_rollover; // RL5
      pend[`IPS_B_KEYPAD]  = keypad_request; // RL6
      pend[`IPS_B_RTC]     = rtc_request; // RL8
      pend[`IPS_B_WDOG]    = watchdog_request; // RL9
      pend[`IPS_B_UART]    = uart_request; // RL10
      pend[`IPS_B_TMR]     = timer_event_flag; // RL11
      pend[`IPS_B_SPI]     = spi_done; // RL12
      stat                 = pend & ~mask_q; // RL18
   end

   // priority level of one pending bit position
   function automatic ips_pkg::ips_level_type lvl_of(input int b);
      ips_pkg::ips_level_type v;
      v = `IPS_LVL_FOUR;
      case (b)
         `IPS_B_LVL1: v = `IPS_LVL_EXT1;
         `IPS_B_PEN:  v = `IPS_LVL_PEN; // RL15
         `IPS_B_PWM:  v = `IPS_LVL_SIX; // RL5
         `IPS_B_TMR:  v = `IPS_LVL_SIX; // RL11
         default:     v = `IPS_LVL_FOUR; // RL4 RL6 RL8 RL9 RL10 RL12
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // per-bit priority levels

   // each unmasked pending bit offers its own level and quiet bits
   // offer none, so the core side only has to pick the largest
   for (genvar b = 0; b < 32; b++)
   begin : g_lvl
      assign bit_level[b] = stat[b] ? lvl_of(b) : `IPS_LVL_NONE;
   end

   ////////////////////////////////////////////////////////////////////////
   // bus answer: next state

   assign addr_ok = (paddr == `IPS_CTRL_ADDR) || (paddr == `IPS_MASK_ADDR)
                 || (paddr == `IPS_STAT_ADDR) || (paddr == `IPS_PEND_ADDR)
                 || (paddr == `IPS_KCLR_ADDR);

   // no wait state: the answer is registered in the setup cycle,
   // so a read shows the word as it stood at setup
   always_comb
   begin
      prdata_d  = prdata_q;
      pready_d  = psel & ~penable;
      pslverr_d = psel & ~penable & ~addr_ok;
      if (psel && !penable)
      begin
         unique case (paddr)
            `IPS_CTRL_ADDR: prdata_d = ctrl_q;
            `IPS_MASK_ADDR: prdata_d = mask_q;
            `IPS_STAT_ADDR: prdata_d = stat;
            `IPS_PEND_ADDR: prdata_d = pend; // RL19
            default:        prdata_d = '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration registers: next state

   // pending is never written here; reserved bits are dropped
   always_comb
   begin
      ctrl_d = ctrl_q;
      mask_d = mask_q;
      if (wr_done && paddr == `IPS_CTRL_ADDR)
      begin
         ctrl_d = pwdata & `IPS_CTRL_BITS;
      end
      if (wr_done && paddr == `IPS_MASK_ADDR)
      begin
         mask_d = pwdata & `IPS_VALID_BITS; // RL3 RL7
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // core side: next state

   // highest unmasked level goes to the core; wake ignores the mask
   // so that a sleeping core still hears a key press
   always_comb
   begin
      level_d = `IPS_LVL_NONE;
      wake_d  = keypad_request; // RL14
      for (int b = 0; b < 32; b++)
      begin
         if (bit_level[b] > level_d)
         begin
            level_d = bit_level[b];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers

   // bus answer flops
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         prdata_q  <= '0;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else
      begin
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // configuration flops
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         ctrl_q <= `IPS_CTRL_RST;
         mask_q <= `IPS_MASK_RST;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         mask_q <= mask_d;
      end
   end

   // core side flops
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         level_q <= `IPS_LVL_NONE;
         wake_q  <= 1'b0;
      end
      else
      begin
         level_q <= level_d;
         wake_q  <= wake_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs straight from flops

   assign prdata       = prdata_q;
   assign pready       = pready_q;
   assign pslverr      = pslverr_q;
   assign irq_level    = level_q;
   assign wake_request = wake_q;
endmodule

// ### rtl/ips_pkg.sv
// types shared by the interrupt pending sources block
package ips_pkg;
   typedef logic [2:0]  ips_level_type;
   typedef logic [31:0] ips_word_type;
   typedef logic [11:0] ips_addr_type;
endpackage

// ### rtl/ips_src_cell.sv
// one external request: edge or level capture with write-one clear
`timescale 1ns/100ps
module ips_src_cell
(
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic active,
   input  wire logic edge_mode,
   input  wire logic clear,
   output logic      pending
);
   logic prev_q;
   logic prev_d;
   logic sticky_q;
   logic sticky_d;

   // a rising active edge beats a clear in the same cycle
   always_comb
   begin
      prev_d   = active;
      sticky_d = 1'b0;
      if (edge_mode)
      begin
         sticky_d = (active & ~prev_q) | (sticky_q & ~clear);
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         prev_q   <= 1'b0;
         sticky_q <= 1'b0;
      end
      else
      begin
         prev_q   <= prev_d;
         sticky_q <= sticky_d;
      end
   end

   // level mode follows the line; writes cannot clear it
   assign pending = edge_mode ? sticky_q : active;
endmodule
